// [hssp_pkg.sv]
// Package for the host serial slave port: frame layout, address, timing.
// Assumes a single 250 MHz system clock; serial pins are asynchronous.
package hssp_pkg;
  localparam int unsigned HSSP_BYTE_BITS = 8;          // Bits per byte
  localparam int unsigned HSSP_ADDR_BITS = 7;          // Register address width
  localparam int unsigned HSSP_HDR_RW_POS = 7;         // Direction bit in header
  localparam logic HSSP_DIR_READ = 1'b1;               // Header read code
  localparam logic HSSP_DIR_WRITE = 1'b0;              // Header write code
  localparam logic [5:0] HSSP_I2C_ADDR_HI = 6'h34;     // Upper six address bits, 110100
  localparam int unsigned HSSP_FIFO_DEPTH = 32;        // Receive buffer depth
  localparam int unsigned HSSP_FIFO_WIDTH = 15;        // Address plus data
  localparam int unsigned HSSP_I2C_PROG_MAX = 30;      // Advisory program length
  localparam int unsigned HSSP_SYNC_STAGES = 2;        // Pin synchroniser depth
  localparam int unsigned HSSP_CLK_MHZ = 250;          // System clock rate
  localparam int unsigned HSSP_SCLK_MAX_KHZ = 6400;    // Fastest serial clock
  // Least system cycles per serial clock period, rounded down
  localparam int unsigned HSSP_SCLK_MIN_CYC = (HSSP_CLK_MHZ * 1000) / HSSP_SCLK_MAX_KHZ;
  typedef enum logic [1:0] {
    HSSP_I2C_IDLE = 2'b00,
    HSSP_I2C_ADDR = 2'b01,
    HSSP_I2C_WR = 2'b10,
    HSSP_I2C_RD = 2'b11
  } hssp_i2c_state_t;
endpackage

// [hssp_fifo.sv]
// Synchronous FIFO with valid/ready on both sides.
// Assumes both sides on mclk; depth is a power of two.
module hssp_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];   // Storage
  logic [AW:0] wr_ptr;             // Write pointer with wrap bit
  logic [AW:0] rd_ptr;             // Read pointer with wrap bit
  logic push;
  logic pop;

  // Full when pointers differ only by wrap bit
  assign in_ready = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data = mem[rd_ptr[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage write
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  // Pointer update
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule // hssp_fifo

// [hssp_port.sv]
// Host serial slave port: SPI four-wire slave and I2C slave front end.
// Assumes pins come from the host asynchronously; register file sits outside.

module hssp_port
  import hssp_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic i2c_mode,
  input wire logic chip_select_n,
  input wire logic sclk_in,
  input wire logic sdi_in,
  output logic sdi_out,
  output logic sdi_oe_n,
  output logic scl_out,
  output logic scl_oe_n,
  output logic sdo_out,
  output logic sdo_oe_n,
  input wire logic addr_select_pin,
  output logic [HSSP_ADDR_BITS-1:0] wr_addr,
  output logic [HSSP_BYTE_BITS-1:0] wr_data,
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [HSSP_ADDR_BITS-1:0] rd_addr,
  output logic rd_req,
  input wire logic [HSSP_BYTE_BITS-1:0] rd_data,
  output logic busy
);
  // Synchronisers for asynchronous pins
  logic [HSSP_SYNC_STAGES-1:0] cs_sync;
  logic [HSSP_SYNC_STAGES-1:0] clk_sync;
  logic [HSSP_SYNC_STAGES-1:0] dat_sync;
  logic [HSSP_SYNC_STAGES-1:0] sel_sync;
  logic cs_q;                               // Previous synced select
  logic clk_q;                              // Previous synced clock
  logic dat_q;                              // Previous synced data
  logic cs_s;
  logic clk_s;
  logic dat_s;
  logic clk_rise;
  logic clk_fall;
  logic cs_fall;
  logic spi_sel;
  // SPI shifter state
  logic [2:0] bit_cnt;                      // Bit within byte
  logic hdr_done;                           // Header received
  logic dir_read;                           // Latched direction
  logic [HSSP_ADDR_BITS-1:0] cur_addr;      // Running register address
  logic [HSSP_BYTE_BITS-1:0] rx_shift;      // Receive shifter
  logic [HSSP_BYTE_BITS-1:0] tx_shift;      // Transmit shifter
  logic tx_bit;                             // Output bit register
  logic sdo_en;                             // Output enabled from first read fall
  // I2C state
  hssp_i2c_state_t i2c_state;
  logic [3:0] i2c_bit;                      // Bit count 0..8, 8 is ack slot
  logic [HSSP_BYTE_BITS-1:0] i2c_shift;
  logic i2c_sda_low;                        // Device pulls data low
  logic i2c_first;                          // Next write byte is address
  logic i2c_ack_nack;                       // Master left ack high
  logic i2c_start;
  logic i2c_stop;
  logic stretch;
  logic addr_lsb;                           // Strap, resampled every cycle
  // Buffer between shifter and register file
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [HSSP_FIFO_WIDTH-1:0] fifo_in_data;
  logic [HSSP_FIFO_WIDTH-1:0] fifo_out_data;
  logic byte_done;
  logic [HSSP_BYTE_BITS-1:0] next_byte;

  // Two-flop synchronisers; first stage feeds only the second
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cs_sync <= '1;
      clk_sync <= '1;
      dat_sync <= '1;
      sel_sync <= '0;
    end else begin
      cs_sync <= {cs_sync[0], chip_select_n};
      clk_sync <= {clk_sync[0], sclk_in};
      dat_sync <= {dat_sync[0], sdi_in};
      sel_sync <= {sel_sync[0], addr_select_pin};
    end
  end

  assign cs_s = cs_sync[1];
  assign clk_s = clk_sync[1];
  assign dat_s = dat_sync[1];

  // Delayed copies for edge finding
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cs_q <= 1'b1;
      clk_q <= 1'b1;
      dat_q <= 1'b1;
    end else begin
      cs_q <= cs_s;
      clk_q <= clk_s;
      dat_q <= dat_s;
    end
  end

  assign spi_sel = !i2c_mode && !cs_s;
  assign cs_fall = cs_q && !cs_s;
  assign clk_rise = !clk_q && clk_s;
  assign clk_fall = clk_q && !clk_s;
  assign i2c_start = i2c_mode && clk_s && clk_q && dat_q && !dat_s;
  assign i2c_stop = i2c_mode && clk_s && clk_q && !dat_q && dat_s;
  assign busy = spi_sel || (i2c_state != HSSP_I2C_IDLE);

  // Address strap follows the synchronised pin on every clock after reset
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      addr_lsb <= 1'b0;
    end else begin
      addr_lsb <= sel_sync[1];
    end
  end

  // Byte completes on the eighth rising edge
  assign next_byte = i2c_mode ? {i2c_shift[6:0], dat_s} : {rx_shift[6:0], dat_s};
  assign byte_done = clk_rise && (i2c_mode ? (i2c_bit == 4'd7) : (bit_cnt == 3'd7));

  // SPI receive side; selection restarts header decode
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      bit_cnt <= '0;
      hdr_done <= 1'b0;
      dir_read <= HSSP_DIR_WRITE;
      cur_addr <= '0;
      rx_shift <= '0;
    end else if (!spi_sel || cs_fall) begin
      // Deselected activity ignored
      bit_cnt <= '0;
      hdr_done <= 1'b0;
    end else if (clk_rise) begin
      rx_shift <= next_byte;
      bit_cnt <= bit_cnt + 3'd1;
      if (bit_cnt == 3'd7) begin
        if (!hdr_done) begin
          hdr_done <= 1'b1;
          dir_read <= next_byte[HSSP_HDR_RW_POS];
          cur_addr <= next_byte[HSSP_ADDR_BITS-1:0];
        end else begin
          cur_addr <= cur_addr + 7'd1;
        end
      end
    end
  end

  // SPI transmit: load at byte start, shift on falling edge
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tx_shift <= '0;
      tx_bit <= 1'b0;
      sdo_en <= 1'b0;
    end else if (!spi_sel) begin
      tx_bit <= 1'b0;
      sdo_en <= 1'b0;
    end else if (clk_fall && hdr_done && dir_read) begin
      // Enable only in the low phase so no edge shows with clock high
      sdo_en <= 1'b1;
      if (bit_cnt == 3'd0) begin
        tx_bit <= rd_data[HSSP_BYTE_BITS-1];
        tx_shift <= {rd_data[6:0], 1'b0};
      end else begin
        tx_bit <= tx_shift[HSSP_BYTE_BITS-1];
        tx_shift <= {tx_shift[6:0], 1'b0};
      end
    end
  end

  // Output driver released while deselected
  assign sdo_out = tx_bit;
  assign sdo_oe_n = !(spi_sel && sdo_en);

  // I2C slave state machine
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      i2c_state <= HSSP_I2C_IDLE;
      i2c_bit <= '0;
      i2c_shift <= '0;
      i2c_first <= 1'b0;
      i2c_ack_nack <= 1'b0;
    end else if (!i2c_mode || i2c_stop) begin
      i2c_state <= HSSP_I2C_IDLE;
      i2c_bit <= '0;
    end else if (i2c_start) begin
      i2c_state <= HSSP_I2C_ADDR;
      i2c_bit <= '0;
      i2c_first <= 1'b1;
    end else if (clk_rise && !stretch) begin
      if (i2c_bit == 4'd8) begin
        // Ninth clock: ack slot
        i2c_bit <= '0;
        i2c_ack_nack <= dat_s;
        if (i2c_state == HSSP_I2C_RD && dat_s) begin
          i2c_state <= HSSP_I2C_IDLE;
        end
      end else begin
        i2c_shift <= next_byte;
        i2c_bit <= i2c_bit + 4'd1;
        if (i2c_bit == 4'd7 && i2c_state == HSSP_I2C_ADDR) begin
          if (next_byte[7:1] == {HSSP_I2C_ADDR_HI, addr_lsb}) begin
            i2c_state <= next_byte[0] ? HSSP_I2C_RD : HSSP_I2C_WR;
          end else begin
            i2c_state <= HSSP_I2C_IDLE;
          end
        end else if (i2c_bit == 4'd7 && i2c_state == HSSP_I2C_WR) begin
          i2c_first <= 1'b0;
        end
      end
    end
  end

  // I2C data drive: ack in write state, data when sending; read address byte not acked
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      i2c_sda_low <= 1'b0;
    end else if (!i2c_mode || i2c_state == HSSP_I2C_IDLE) begin
      i2c_sda_low <= 1'b0;
    end else if (clk_fall) begin
      if (i2c_bit == 4'd8 && i2c_state != HSSP_I2C_RD) begin
        i2c_sda_low <= 1'b1;
      end else if (i2c_state == HSSP_I2C_RD && i2c_bit != 4'd8) begin
        i2c_sda_low <= !rd_data[3'd7 - i2c_bit[2:0]];
      end else begin
        i2c_sda_low <= 1'b0;
      end
    end
  end

  // Clock stretch while the buffer cannot take a byte
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      stretch <= 1'b0;
    end else begin
      stretch <= i2c_mode && (i2c_state == HSSP_I2C_WR) && !clk_s && !fifo_in_ready;
    end
  end

  // Open-drain pins: enable low means driving low
  // Slave only: never a driven high level, select is input only
  assign sdi_out = 1'b0;
  assign sdi_oe_n = !i2c_sda_low;
  assign scl_out = 1'b0;
  assign scl_oe_n = !stretch;

  // Register address for reads and the read strobe
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rd_addr <= '0;
      rd_req <= 1'b0;
    end else begin
      rd_req <= spi_sel && hdr_done && dir_read && clk_fall && bit_cnt == 3'd0;
      rd_addr <= i2c_mode ? i2c_shift[HSSP_ADDR_BITS-1:0] : cur_addr;
    end
  end

  // Write bytes into the buffer; header or I2C address byte excluded
  assign fifo_in_valid = byte_done && ((spi_sel && hdr_done && !dir_read)
                         || (i2c_state == HSSP_I2C_WR && !i2c_first));
  assign fifo_in_data = {i2c_mode ? i2c_shift[HSSP_ADDR_BITS-1:0] : cur_addr, next_byte};

  hssp_fifo #(
    .WIDTH(HSSP_FIFO_WIDTH),
    .DEPTH(HSSP_FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .reset_n(reset_n),
    .in_data(fifo_in_data),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out_data),
    .out_valid(wr_valid),
    .out_ready(wr_ready)
  );

  assign wr_addr = fifo_out_data[HSSP_FIFO_WIDTH-1:HSSP_BYTE_BITS];
  assign wr_data = fifo_out_data[HSSP_BYTE_BITS-1:0];
endmodule // hssp_port

// [hssp_port_chk.sv]
// Checker for the host serial slave port, seeing only its pins.
// Assumes the bind below; deselect and mode are quiet between frames.
module hssp_port_chk (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic i2c_mode,
  input wire logic chip_select_n,
  input wire logic sclk_in,
  input wire logic sdi_out,
  input wire logic sdi_oe_n,
  input wire logic scl_out,
  input wire logic scl_oe_n,
  input wire logic sdo_out,
  input wire logic sdo_oe_n,
  input wire logic rd_req,
  input wire logic busy
);
  // One domain: mclk, reset_n
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sdo_hiz_a: assert property (chip_select_n [*6] |-> sdo_oe_n)
    else $error("data out driven while deselected");
  scl_pull_a: assert property (!scl_oe_n |-> !scl_out && i2c_mode)
    else $error("clock pin driven badly");
  sda_pull_a: assert property (!sdi_oe_n |-> !sdi_out && i2c_mode)
    else $error("data pin driven badly");
  sda_low_clk_a: assert property ($changed(sdi_oe_n) |-> !sclk_in)
    else $error("data pin moved with clock high");
  sdo_on_fall_a: assert property (!sdo_oe_n && $changed(sdo_out) |-> !sclk_in)
    else $error("data out moved with clock high");
  sdo_start_a: assert property ($fell(sdo_oe_n) |-> !sclk_in && !chip_select_n)
    else $error("data out enabled out of place");
  rd_pulse_a: assert property (rd_req |-> !sclk_in ##1 !rd_req [*8])
    else $error("read request not a lone pulse");
  busy_idle_a: assert property ((chip_select_n && !i2c_mode) [*6] |-> !busy)
    else $error("busy while deselected");
  busy_sel_a: assert property ((!chip_select_n && !i2c_mode) [*6] |-> busy)
    else $error("not busy while selected");
endmodule // hssp_port_chk

bind hssp_port hssp_port_chk u_hssp_port_chk (
  .mclk, .reset_n, .i2c_mode, .chip_select_n, .sclk_in, .sdi_out, .sdi_oe_n,
  .scl_out, .scl_oe_n, .sdo_out, .sdo_oe_n, .rd_req, .busy
);

// [hssp_host.sv]
// Host master model: select, clock and data pins, open-drain resolution.
// Assumes mclk of 4 ns; one link half period is HALF mclk cycles.
module hssp_host #(
  parameter int HALF = 20
) (
  input wire logic mclk,
  input wire logic sdi_oe_n,
  input wire logic scl_oe_n,
  input wire logic sdo_out,
  input wire logic sdo_oe_n,
  output logic chip_select_n,
  output logic sclk_in,
  output logic sdi_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic m_scl = 1'b1; // Clock drive
  logic m_sda = 1'b1; // Data drive
  logic last = 1'b0; // Last bit seen
  initial chip_select_n = 1'b1;
  // Pulled-up lines: either party may pull low
  assign sclk_in = m_scl & scl_oe_n;
  assign sdi_in = m_sda & sdi_oe_n;
  // 80 ns half period keeps the clock under 6.4 MHz
  task automatic half();
    repeat (HALF) @(posedge mclk);
  endtask
  // Byte MSB first, set in low phase, read at rise
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      m_scl <= 1'b0;
      repeat (HALF / 2) @(posedge mclk);
      m_sda <= tx[i];
      repeat (HALF / 2) @(posedge mclk);
      m_scl <= 1'b1;
      // Wait out a held clock
      while (sclk_in !== 1'b1)
        @(posedge mclk);
      // Released output reads as a changing level
      last = sdo_oe_n ? ~last : sdo_out;
      rx[i] = last;
      half();
    end
  endtask
  // Select low frames the transfer
  task automatic spi_begin();
    chip_select_n <= 1'b0;
    half();
  endtask
  task automatic spi_end();
    half();
    chip_select_n <= 1'b1;
    m_sda <= ~m_sda;
    half();
  endtask
  // Start: data falls with clock high
  task automatic i2c_start();
    m_sda <= 1'b1;
    half();
    m_sda <= 1'b0;
    half();
  endtask
  // Ninth clock: release data, read acknowledge
  task automatic i2c_ack(output logic ack);
    m_scl <= 1'b0;
    half();
    m_sda <= 1'b1;
    m_scl <= 1'b1;
    half();
    ack = ~sdi_in;
  endtask
  // Stop: data rises with clock high
  task automatic i2c_stop();
    m_scl <= 1'b0;
    m_sda <= 1'b0;
    half();
    m_scl <= 1'b1;
    half();
    m_sda <= 1'b1;
    half();
  endtask
  // Clock and data toggling while deselected
  task automatic noise();
    repeat (16) begin
      m_scl <= ~m_scl;
      m_sda <= ~m_sda;
      half();
    end
  endtask
endmodule // hssp_host

// [hssp_port_test.sv]
// Testbench for the host serial slave port against the host model.
// Assumes the port, its buffer, the model and the checker are compiled.
module hssp_port_test
  import hssp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, reset_n = 1'b0, i2c_mode = 1'b0, addr_select_pin = 1'b0;
  logic wr_ready = 1'b0, rd_req, busy, wr_valid;
  logic chip_select_n, sclk_in, sdi_in, sdi_out, sdi_oe_n, scl_out, scl_oe_n, sdo_out, sdo_oe_n;
  logic [6:0] wr_addr, rd_addr;
  logic [7:0] wr_data, rd_data = 8'h00;
  int bad_count = 0, tests_run = 0;
  hssp_port u_hssp_port (.mclk, .reset_n, .i2c_mode, .chip_select_n, .sclk_in, .sdi_in,
    .sdi_out, .sdi_oe_n, .scl_out, .scl_oe_n, .sdo_out, .sdo_oe_n, .addr_select_pin,
    .wr_addr, .wr_data, .wr_valid, .wr_ready, .rd_addr, .rd_req, .rd_data, .busy);
  hssp_host u_hssp_host (.mclk, .sdi_oe_n, .scl_oe_n, .sdo_out, .sdo_oe_n,
    .chip_select_n, .sclk_in, .sdi_in);
  initial begin
    forever #2 mclk = ~mclk;
  end
  // Register file stand-in, answers one cycle after the address
  always @(posedge mclk) rd_data <= {1'b1, rd_addr} ^ 8'h3c;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    if (bad_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Burst past buffer depth with the sink stalled, then drain
  task automatic t_write();
    logic [7:0] rx;
    int n = 0;
    u_hssp_host.spi_begin();
    u_hssp_host.xfer({HSSP_DIR_WRITE, 7'h7e}, rx);
    for (int i = 0; i <= HSSP_FIFO_DEPTH; i++) u_hssp_host.xfer(8'ha0 + 8'(i), rx);
    u_hssp_host.spi_end();
    wr_ready <= 1'b1;
    for (int k = 0; k < 200; k++) begin
      @(negedge mclk);
      if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
        check({wr_addr, wr_data}, {7'(7'h7e + n), 8'ha0 + 8'(n)});
        n++;
      end
    end
    check(n, HSSP_FIFO_DEPTH);
  endtask
  // Burst read across the top address
  task automatic t_read();
    logic [7:0] rx;
    u_hssp_host.spi_begin();
    u_hssp_host.xfer({HSSP_DIR_READ, 7'h7f}, rx);
    for (int i = 0; i < 3; i++) begin
      u_hssp_host.xfer(8'h00, rx);
      check(rx, {1'b1, 7'(7'h7f + i)} ^ 8'h3c);
    end
    u_hssp_host.spi_end();
    check(sdo_oe_n, 1'b1);
  endtask
  // Deselected activity ignored; next frame decodes afresh
  task automatic t_idle();
    logic [7:0] rx;
    wr_ready <= 1'b0;
    u_hssp_host.noise();
    check({busy, wr_valid, sdo_oe_n}, 3'h1);
    u_hssp_host.spi_begin();
    u_hssp_host.xfer({HSSP_DIR_WRITE, 7'h05}, rx);
    u_hssp_host.xfer(8'h99, rx);
    u_hssp_host.spi_end();
    check({wr_valid, wr_addr, wr_data}, {1'b1, 7'h05, 8'h99});
    wr_ready <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask
  // Address match by strap, then a miss; one-byte programs
  task automatic t_i2c();
    logic [7:0] rx;
    logic ack;
    i2c_mode <= 1'b1;
    addr_select_pin <= 1'b1;
    repeat (4) @(posedge mclk);
    u_hssp_host.i2c_start();
    u_hssp_host.xfer({6'h34, 1'b1, 1'b0}, rx);
    u_hssp_host.i2c_ack(ack);
    check(ack, 1'b1);
    u_hssp_host.i2c_stop();
    u_hssp_host.i2c_start();
    u_hssp_host.xfer({6'h34, 1'b0, 1'b0}, rx);
    u_hssp_host.i2c_ack(ack);
    check(ack, 1'b0);
    u_hssp_host.i2c_stop();
    check(busy, 1'b0);
    i2c_mode <= 1'b0;
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    t_write();
    t_read();
    t_idle();
    t_i2c();
    close_out();
  end
  // Watchdog well past the expected run length
  initial begin
    repeat (40000) @(posedge mclk);
    bad_count++;
    close_out();
  end
endmodule // hssp_port_test
